// *** core/nvs_pkg.sv ***
// Purpose: shared constants and types of the two-wire memory link
// Assumes: 200 MHz system clock on both ends
// Notes: host register offsets and command codes live here too

`default_nettype none

// ****************************************************
// package
// ****************************************************
package nvs_pkg;
    localparam int NVS_MEM_DEPTH = 512;
    localparam int NVS_ADDR_W = 9;
    localparam int NVS_UNIT_W = 8;
    // arbitrary value, both ends must agree
    localparam logic [3:0] NVS_TYPE_CODE = 4'h5;

    // first unit layout, msb first
    localparam int NVS_FW_TYPE_LSB = 4;
    localparam int NVS_FW_SEL_HI = 3;
    localparam int NVS_FW_SEL_LO = 2;
    localparam int NVS_FW_UPPER = 1;
    localparam int NVS_FW_DIR = 0;

    // link clock timing
    localparam int NVS_CLK_PERIOD_NS = 5;
    localparam int NVS_SCL_MIN_PERIOD_NS = 1000;
    localparam int NVS_QTR_CYC = (NVS_SCL_MIN_PERIOD_NS
        + 4 * NVS_CLK_PERIOD_NS - 1) / (4 * NVS_CLK_PERIOD_NS);

    // host register map
    localparam int NVS_REG_AW = 4;
    localparam logic [3:0] NVS_REG_CMD = 4'h0;
    localparam logic [3:0] NVS_REG_TX = 4'h4;
    localparam logic [3:0] NVS_REG_RX = 4'h8;
    localparam logic [3:0] NVS_REG_STAT = 4'hc;
    localparam int NVS_CMD_NACK_BIT = 2;
    localparam int NVS_STAT_BUSY_BIT = 0;
    localparam int NVS_STAT_NACK_BIT = 1;

    typedef enum logic [1:0] {
        NVS_OP_START,
        NVS_OP_WRITE,
        NVS_OP_READ,
        NVS_OP_STOP
    } nvs_op_t;
endpackage : nvs_pkg

`default_nettype wire

// *** core/nvs_if.sv ***
// Purpose: two-wire link between host end and memory end
// Assumes: data line is wired-and with a pull-up
// Notes: the resolved level is worked out here from the enables

`timescale 1ns/1ps
`default_nettype none

interface nvs_if;
    logic scl;
    logic sda;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic host_sda_o;
    logic host_sda_oe;

    // ****************************************************
    // wired-and data line with pull-up
    // ****************************************************
    assign sda = !((dev_sda_oe && !dev_sda_o)
                   || (host_sda_oe && !host_sda_o));

    modport dev (
        input scl,
        input sda,
        output dev_sda_o,
        output dev_sda_oe
    );
    modport host (
        output scl,
        input sda,
        output host_sda_o,
        output host_sda_oe
    );
endinterface : nvs_if

`default_nettype wire

// *** core/nvs_host.sv ***
// Purpose: link master, one byte-level operation per command
// Assumes: software polls the busy bit before the next command
// Notes: link clock made by a quarter-period divider

`timescale 1ns/1ps
`default_nettype none

module nvs_host (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    nvs_if.host bus,
    input wire logic [nvs_pkg::NVS_REG_AW-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata
);
    import nvs_pkg::*;

    typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} nvs_hst_t;

    typedef struct packed {
        nvs_hst_t st;
        logic [1:0] q;
        logic [7:0] tick;
        logic [3:0] bitn;
        logic [8:0] sh;
        logic is_wr;
        logic [7:0] tx;
        logic [7:0] rx;
        logic nack;
        logic busy;
        logic scl;
        logic sda_o;
        logic sda_oe;
        logic [1:0] sync;
        logic [7:0] rdata;
    } nvs_hreg_t;

    localparam nvs_hreg_t H_RST = '{st: H_IDLE, scl: 1'b1, default: '0};
    localparam logic [7:0] QTR_LAST = 8'(NVS_QTR_CYC - 1);

    nvs_hreg_t r;
    nvs_hreg_t next_r;
    logic sda;
    logic qend;

    // ****************************************************
    // next state
    // ****************************************************
    always_comb begin
        next_r = r;
        next_r.sync = {r.sync[0], bus.sda};
        sda = r.sync[1];
        qend = r.busy && (r.tick == QTR_LAST);
        next_r.rdata = 8'h00;
        if (rd) begin
            case (addr)
                NVS_REG_TX: next_r.rdata = r.tx;
                NVS_REG_RX: next_r.rdata = r.rx;
                NVS_REG_STAT: next_r.rdata = {6'h00, r.nack, r.busy};
                default: next_r.rdata = 8'h00;
            endcase
        end
        if (wr && addr == NVS_REG_TX) begin
            next_r.tx = wdata;
        end
        if (wr && addr == NVS_REG_CMD && !r.busy) begin
            next_r.busy = 1'b1;
            next_r.q = 2'h0;
            next_r.tick = 8'h00;
            next_r.bitn = 4'h0;
            case (nvs_op_t'(wdata[1:0]))
                NVS_OP_START: next_r.st = H_START;
                NVS_OP_WRITE: begin
                    next_r.sh = {r.tx, 1'b1};
                    next_r.is_wr = 1'b1;
                    next_r.st = H_BIT;
                end
                NVS_OP_READ: begin
                    next_r.sh = {8'hff, wdata[NVS_CMD_NACK_BIT]};
                    next_r.is_wr = 1'b0;
                    next_r.st = H_BIT;
                end
                default: next_r.st = H_STOP;
            endcase
        end
        if (r.busy) begin
            next_r.tick = qend ? 8'h00 : r.tick + 8'h01;
        end
        if (qend) begin
            next_r.q = r.q + 2'h1;
            case (r.st)
                H_START: begin
                    case (r.q)
                        // clock kept as is: high from idle, low after a bit
                        2'h0: next_r.sda_oe = 1'b0;
                        2'h1: next_r.scl = 1'b1;
                        2'h2: next_r.sda_oe = 1'b1;
                        default: begin
                            next_r.scl = 1'b0;
                            next_r.busy = 1'b0;
                            next_r.st = H_IDLE;
                        end
                    endcase
                end
                // data moves only with clock low
                H_BIT: begin
                    case (r.q)
                        2'h0: next_r.sda_oe = !r.sh[8];
                        2'h1: next_r.scl = 1'b1;
                        2'h2: next_r.sh = {r.sh[7:0], sda};
                        default: begin
                            next_r.scl = 1'b0;
                            next_r.bitn = r.bitn + 4'h1;
                            if (r.bitn == 4'h8) begin
                                next_r.busy = 1'b0;
                                next_r.st = H_IDLE;
                                next_r.rx = r.sh[8:1];
                                if (r.is_wr) begin
                                    next_r.nack = r.sh[0];
                                end
                            end
                        end
                    endcase
                end
                H_STOP: begin
                    case (r.q)
                        2'h0: next_r.sda_oe = 1'b1;
                        2'h1: next_r.scl = 1'b1;
                        2'h2: next_r.sda_oe = 1'b0;
                        default: begin
                            next_r.busy = 1'b0;
                            next_r.st = H_IDLE;
                        end
                    endcase
                end
                default: next_r.st = H_IDLE;
            endcase
        end
    end

    // ****************************************************
    // state register
    // ****************************************************
    // quarter divider caps clock rate
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= H_RST;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign bus.scl = r.scl;
    assign bus.host_sda_o = r.sda_o;
    assign bus.host_sda_oe = r.sda_oe;
    assign rdata = r.rdata;
endmodule : nvs_host

`default_nettype wire

// *** core/nvs_dev.sv ***
// Purpose: two-wire slave front end of a 512 x 8 memory
// Assumes: link clock far slower than clk, pins sampled twice
// Notes: byte address then data with increment; lock blocks writes
//
// The plain strobed port and the register offsets were left to the implementer.

`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - 512 bytes, nine-bit address
// - master keeps clock at or below 1 MHz
// - act only when select bits match straps
// - data line driven low or released
// - sample on rise, change on fall
// - write lock high rejects all writes
// - reads allowed whatever the lock
// - only master starts and clocks transfers
// - data changes only while clock low
// - falling data with clock high starts
// - stop ends transfer, back to standby
// - ready again at once after stop
// - eight-bit units plus ack clock
// - receiver pulls low on ninth clock
// - transmitter releases line on ack clock
// - stop before ack aborts to standby
// - after nack release bus, drive nothing
// - after nack master sends stop/restart
// - first unit: type, select, upper, direction
// - direction zero writes, one reads
// - mismatched first unit leaves device standby
module nvs_dev #(
    parameter logic [3:0] TYPE_CODE = nvs_pkg::NVS_TYPE_CODE,
    parameter int DEPTH = nvs_pkg::NVS_MEM_DEPTH
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    nvs_if.dev bus,
    input wire logic select_strap_low,
    input wire logic select_strap_high,
    input wire logic write_lock,
    output logic selected,
    output logic lock_reject
);
    import nvs_pkg::*;

    typedef enum logic [2:0] {
        D_IDLE,
        D_RX,
        D_RXACK,
        D_TX,
        D_TXACK
    } nvs_dst_t;

    // pin vector positions
    localparam int P_SCL = 4;
    localparam int P_SDA = 3;
    localparam int P_LOCK = 2;
    localparam int P_HI = 1;
    localparam int P_LO = 0;

    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic scl_q;
        logic sda_q;
        nvs_dst_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic first;
        logic got_addr;
        logic rd;
        logic acked;
        logic [NVS_ADDR_W-1:0] addr;
        logic sda_o;
        logic sda_oe;
        logic selected;
        logic lock_reject;
        logic wr_en;
        logic [NVS_ADDR_W-1:0] wr_addr;
        logic [7:0] wr_data;
    } nvs_dreg_t;
    localparam nvs_dreg_t D_RST = '{s1: 5'h18, s2: 5'h18, scl_q: 1'b1,
        sda_q: 1'b1, st: D_IDLE, default: '0};

    nvs_dreg_t r;
    nvs_dreg_t next_r;
    logic [NVS_UNIT_W-1:0] mem [DEPTH];
    logic scl;
    logic sda;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic [NVS_ADDR_W-1:0] rd_addr;
    logic [7:0] rd_byte;

    // ****************************************************
    // helpers
    // ****************************************************
    function automatic logic [NVS_ADDR_W-1:0] addr_inc(
        input logic [NVS_ADDR_W-1:0] a
    );
        addr_inc = NVS_ADDR_W'(a + 1'b1);
    endfunction : addr_inc

    function automatic logic unit_match(
        input logic [7:0] u,
        input logic hi,
        input logic lo
    );
        unit_match = (u[7:NVS_FW_TYPE_LSB] == TYPE_CODE)
                     && (u[NVS_FW_SEL_HI] == hi)
                     && (u[NVS_FW_SEL_LO] == lo);
    endfunction : unit_match

    // ****************************************************
    // next state
    // ****************************************************
    always_comb begin
        next_r = r;
        next_r.wr_en = 1'b0;
        next_r.lock_reject = 1'b0;
        next_r.sda_o = 1'b0;
        next_r.s1 = {bus.scl, bus.sda, write_lock, select_strap_high,
                     select_strap_low};
        next_r.s2 = r.s1;
        next_r.scl_q = r.s2[P_SCL];
        next_r.sda_q = r.s2[P_SDA];
        scl = r.s2[P_SCL];
        sda = r.s2[P_SDA];
        rise = scl && !r.scl_q;
        fall = !scl && r.scl_q;
        start = scl && r.scl_q && r.sda_q && !sda;
        stop = scl && r.scl_q && !r.sda_q && sda;
        rd_addr = (r.st == D_TXACK) ? addr_inc(r.addr) : r.addr;
        rd_byte = mem[rd_addr];

        if (start) begin
            next_r.st = D_RX;
            next_r.cnt = 4'h0;
            next_r.first = 1'b1;
            next_r.acked = 1'b0;
            next_r.sda_oe = 1'b0;
            next_r.selected = 1'b0;
        end else if (stop) begin
            next_r.st = D_IDLE;
            next_r.sda_oe = 1'b0;
            next_r.selected = 1'b0;
            next_r.acked = 1'b0;
        end else begin
            case (r.st)
                D_RX: begin
                    if (rise) begin
                        next_r.sh = {r.sh[6:0], sda};
                        next_r.cnt = r.cnt + 4'h1;
                    end else if (fall && r.cnt == 4'h8) begin
                        next_r.st = D_RXACK;
                        next_r.sda_oe = 1'b1;
                        if (r.first) begin
                            next_r.first = 1'b0;
                            next_r.got_addr = 1'b0;
                            next_r.addr[NVS_ADDR_W-1] = r.sh[NVS_FW_UPPER];
                            next_r.rd = r.sh[NVS_FW_DIR];
                            next_r.selected = 1'b1;
                            if (!unit_match(r.sh, r.s2[P_HI], r.s2[P_LO]))
                            begin
                                next_r.st = D_IDLE;
                                next_r.sda_oe = 1'b0;
                                next_r.selected = 1'b0;
                            end
                        end else if (!r.got_addr) begin
                            next_r.addr[7:0] = r.sh;
                            next_r.got_addr = 1'b1;
                        end else begin
                            if (r.s2[P_LOCK]) begin
                                next_r.lock_reject = 1'b1;
                            end else begin
                                next_r.wr_en = 1'b1;
                                next_r.wr_addr = r.addr;
                                next_r.wr_data = r.sh;
                            end
                            next_r.addr = addr_inc(r.addr);
                        end
                    end
                end
                D_RXACK: begin
                    if (fall) begin
                        next_r.sda_oe = 1'b0;
                        next_r.cnt = 4'h0;
                        if (r.rd) begin
                            next_r.st = D_TX;
                            next_r.sh = rd_byte;
                            next_r.sda_oe = !rd_byte[7];
                            next_r.cnt = 4'h1;
                        end else begin
                            next_r.st = D_RX;
                        end
                    end
                end
                D_TX: begin
                    if (fall) begin
                        if (r.cnt == 4'h8) begin
                            next_r.st = D_TXACK;
                            next_r.sda_oe = 1'b0;
                        end else begin
                            next_r.sh = {r.sh[6:0], 1'b0};
                            next_r.sda_oe = !r.sh[6];
                            next_r.cnt = r.cnt + 4'h1;
                        end
                    end
                end
                D_TXACK: begin
                    if (rise) begin
                        if (sda) begin
                            next_r.st = D_IDLE;
                            next_r.selected = 1'b0;
                        end else begin
                            next_r.acked = 1'b1;
                        end
                    end else if (fall && r.acked) begin
                        next_r.acked = 1'b0;
                        next_r.addr = rd_addr;
                        next_r.st = D_TX;
                        next_r.sh = rd_byte;
                        next_r.sda_oe = !rd_byte[7];
                        next_r.cnt = 4'h1;
                    end
                end
                default: next_r.st = D_IDLE;
            endcase
        end
    end

    // ****************************************************
    // state register and array
    // ****************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= D_RST;
        end else if (ce) begin
            r <= next_r;
        end
    end

    always_ff @(posedge clk) begin
        if (ce && r.wr_en) begin
            mem[r.wr_addr] <= r.wr_data;
        end
    end

    assign bus.dev_sda_o = r.sda_o;
    assign bus.dev_sda_oe = r.sda_oe;
    assign selected = r.selected;
    assign lock_reject = r.lock_reject;
endmodule : nvs_dev

`default_nettype wire

// *** verification/nvs_monitor.sv ***
// Purpose: wire-level checks of the two-wire memory link
// Assumes: one host end and one memory end on the link
// Notes: instantiated beside the interface, no bind

`timescale 1ns/1ps
`default_nettype none

module nvs_monitor (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic selected,
    input wire logic lock_reject,
    input wire logic write_lock
);
    logic scl_q;
    logic [7:0] since_fall;
    logic [7:0] since_chg;

    // ********************
    // link clock age counters
    // ********************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_q <= 1'b1;
            since_fall <= 8'hff;
            since_chg <= 8'hff;
        end else begin
            scl_q <= scl;
            if (scl_q && !scl) since_fall <= 8'h01;
            else if (since_fall != 8'hff) since_fall <= since_fall + 8'h01;
            if (scl_q != scl) since_chg <= 8'h01;
            else if (since_chg != 8'hff) since_chg <= since_chg + 8'h01;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // ********************
    // properties
    // ********************
    dev_low_only_a: assert property (
        dev_sda_oe |-> !dev_sda_o) else $error("device drives line high");
    host_low_only_a: assert property (
        host_sda_oe |-> !host_sda_o) else $error("host drives line high");
    dev_chg_low_a: assert property (
        $changed(dev_sda_oe) |-> !scl) else $error("device data moved, clock high");
    dev_fall_edge_a: assert property (
        $changed(dev_sda_oe) |-> since_fall <= 8'h0a)
        else $error("device data not changed after clock fall");
    scl_rate_a: assert property (
        $changed(scl) |-> since_chg >= 8'h5a) else $error("link clock too fast");
    start_drop_a: assert property (
        $fell(sda) && scl |-> ##[1:8] !selected)
        else $error("start did not restart device");
    stop_idle_a: assert property (
        $rose(sda) && scl |-> ##[1:8] (!selected && !dev_sda_oe))
        else $error("stop did not reach standby");
    ack_select_a: assert property (
        $rose(dev_sda_oe) |-> selected)
        else $error("ack without selection");
    lock_only_a: assert property (
        lock_reject |-> write_lock && selected) else $error("reject without lock");
endmodule : nvs_monitor

`default_nettype wire

// *** verification/serial_nvram_i2c_slave_tb.sv ***
// Purpose: host end against memory end over the two-wire link
// Assumes: both ends share one 200 MHz clock
// Notes: stimulus through host registers, pins watched directly

`timescale 1ns/1ps
`default_nettype none

module serial_nvram_i2c_slave_tb;
    import nvs_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic strap_lo = 1'b0;
    logic strap_hi = 1'b0;
    logic write_lock = 1'b0;
    logic selected;
    logic lock_reject;
    logic [7:0] n_rej = 8'h00;
    logic [7:0] st;
    logic [7:0] rx;
    int fail_count = 0;
    int n_compared = 0;

    nvs_if bus();
    always #2.5 clk = ~clk;
    always @(posedge clk) if (lock_reject === 1'b1) n_rej <= n_rej + 8'h01;

    nvs_host u_nvs_host (.clk(clk), .arst_n(arst_n), .ce(ce), .bus(bus),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    nvs_dev u_nvs_dev (.clk(clk), .arst_n(arst_n), .ce(ce), .bus(bus),
        .select_strap_low(strap_lo), .select_strap_high(strap_hi),
        .write_lock(write_lock), .selected(selected),
        .lock_reject(lock_reject));
    nvs_monitor u_nvs_monitor (.clk(clk), .arst_n(arst_n), .scl(bus.scl),
        .sda(bus.sda), .dev_sda_o(bus.dev_sda_o),
        .dev_sda_oe(bus.dev_sda_oe), .host_sda_o(bus.host_sda_o),
        .host_sda_oe(bus.host_sda_oe), .selected(selected),
        .lock_reject(lock_reject), .write_lock(write_lock));

    // ********************
    // shared tasks
    // ********************
    task automatic check(input string name, input logic [7:0] exp,
            input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task automatic xfer(input nvs_op_t op, input logic [7:0] tx,
            input logic ackb);
        int n;
        n = 0;
        st = 8'h01;
        wr_reg(NVS_REG_TX, tx);
        wr_reg(NVS_REG_CMD, {5'h00, ackb, op});
        while (st[NVS_STAT_BUSY_BIT] !== 1'b0 && n < 4000) begin
            rd_reg(NVS_REG_STAT, st);
            n++;
        end
        if (n >= 4000) check("busy", 8'h00, st);
        rd_reg(NVS_REG_RX, rx);
    endtask : xfer

    task automatic start_c();
        xfer(NVS_OP_START, 8'h00, 1'b0);
    endtask : start_c

    task automatic stop_c();
        xfer(NVS_OP_STOP, 8'h00, 1'b0);
    endtask : stop_c

    task automatic send(input logic [7:0] b, input logic nack);
        xfer(NVS_OP_WRITE, b, 1'b0);
        check("ack bit", {7'h00, nack}, {7'h00, st[NVS_STAT_NACK_BIT]});
    endtask : send

    task automatic recv(input logic ackb, input logic [7:0] exp);
        xfer(NVS_OP_READ, 8'h00, ackb);
        check("read data", exp, rx);
    endtask : recv

    function automatic logic [7:0] fw(input logic [1:0] s, input logic up,
            input logic dir);
        return {NVS_TYPE_CODE, s, up, dir};
    endfunction : fw

    // ********************
    // scenarios
    // ********************
    task automatic sc_idle();
        check("scl idle", 8'h01, {7'h00, bus.scl});
        check("sda idle", 8'h01, {7'h00, bus.sda});
        wr_reg(4'h6, 8'hff);
        rd_reg(4'h6, st);
        check("unmapped", 8'h00, st);
        wr_reg(NVS_REG_TX, 8'h96);
        rd_reg(NVS_REG_TX, st);
        check("tx readback", 8'h96, st);
        // strobe while frozen must be lost
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(NVS_REG_TX, 8'h69);
        ce <= 1'b1;
        rd_reg(NVS_REG_TX, st);
        check("frozen write", 8'h96, st);
    endtask : sc_idle

    task automatic sc_select();
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            {strap_hi, strap_lo} <= 2'(k);
            start_c();
            send(fw(2'(k), 1'b0, 1'b0), 1'b0);
            check("selected", 8'h01, {7'h00, selected});
            stop_c();
            check("standby", 8'h00, {7'h00, selected});
            start_c();
            send(fw(2'(k) ^ (k[0] ? 2'h2 : 2'h1), 1'b0, 1'b0), 1'b1);
            stop_c();
        end
        start_c();
        send({~NVS_TYPE_CODE, 2'h3, 2'h0}, 1'b1);
        stop_c();
    endtask : sc_select

    task automatic sc_write_read();
        start_c();
        send(fw(2'h3, 1'b1, 1'b0), 1'b0);
        send(8'hff, 1'b0);
        send(8'h3c, 1'b0);
        send(8'h5a, 1'b0);
        stop_c();
        start_c();
        send(fw(2'h3, 1'b1, 1'b0), 1'b0);
        send(8'hff, 1'b0);
        start_c();
        send(fw(2'h3, 1'b1, 1'b1), 1'b0);
        recv(1'b0, 8'h3c);
        recv(1'b1, 8'h5a);
        repeat (20) @(posedge clk);
        check("released", 8'h00, {6'h00, selected, bus.dev_sda_oe});
        stop_c();
    endtask : sc_write_read

    task automatic sc_lock();
        logic [7:0] r0;
        @(posedge clk);
        write_lock <= 1'b1;
        r0 = n_rej;
        start_c();
        send(fw(2'h3, 1'b0, 1'b0), 1'b0);
        send(8'h00, 1'b0);
        send(8'hc3, 1'b0);
        stop_c();
        check("rejects", 8'h01, n_rej - r0);
        start_c();
        send(fw(2'h3, 1'b0, 1'b0), 1'b0);
        send(8'h00, 1'b0);
        start_c();
        send(fw(2'h3, 1'b0, 1'b1), 1'b0);
        recv(1'b1, 8'h5a);
        stop_c();
        @(posedge clk);
        write_lock <= 1'b0;
    endtask : sc_lock

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        sc_idle();
        sc_select();
        sc_write_read();
        sc_lock();
        end_sim();
    end

    // hang guard, about one and a half times the expected run
    initial begin
        #400000;
        fail_count++;
        end_sim();
    end
endmodule : serial_nvram_i2c_slave_tb

`default_nettype wire
